// File: hw/task_sched_regs.vh
// constants of the cyclic task scheduler
`ifndef TASK_SCHED_REGS_VH
`define TASK_SCHED_REGS_VH

`define CLK_PERIOD_NS    10
`define TICK_NS          1000000
`define CYC_PER_MS       (`TICK_NS / `CLK_PERIOD_NS)

`define MAIN_MS_1        3'h1
`define MAIN_MS_2        3'h2
`define MAIN_MS_4        3'h4
`define PER_MS_MIN       7'h01
`define PER_MS_MAX       7'h64

`define ERR_NONE         16'h0000
`define ERR_MAIN_PERIOD  16'h0051
`define ERR_PER_MULT     16'h0052
`define ERR_MAIN_OVR     16'h0061
`define ERR_PER_OVR      16'h0062
`define ERR_INIT_OVR     16'h0063

`define PH_NONE          3'h0
`define PH_REFRESH       3'h1
`define PH_MAIN_PROG     3'h2
`define PH_MOTION        3'h3
`define PH_NET           3'h4
`define PH_INIT_PROG     3'h5

`define N_REAL_AXES      32
`define N_VIRT_AXES      4
`define N_DIN            8
`define N_DOUT           8
`define N_REMOTE         4

`endif

// File: hw/ms_tick_gen.v
// free-running millisecond tick generator
`timescale 1ns/100ps
module ms_tick_gen
#(
	parameter DIV = 100000
)
(
	input  wire sys_clk_in,
	input  wire rst_in,
	output reg  tick_out
);
	reg [16:0] count;

	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			count <= 17'h00000;
			tick_out <= 1'b0;
		end
		else if (count == DIV[16:0] - 17'h00001)
		begin
			count <= 17'h00000;
			tick_out <= 1'b1;
		end
		else
		begin
			count <= count + 17'h00001;
			tick_out <= 1'b0;
		end
	end
endmodule

// File: hw/period_counter.v
// counts strobes and pulses once every limit strobes
`timescale 1ns/100ps
module period_counter
(
	input  wire       sys_clk_in,
	input  wire       rst_in,
	input  wire       restart_in,
	input  wire       strobe_in,
	input  wire [6:0] limit_in,
	output reg        tick_out
);
	reg [6:0] count;

	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			count <= 7'h00;
			tick_out <= 1'b0;
		end
		else if (restart_in)
		begin
			count <= 7'h00;
			tick_out <= 1'b0;
		end
		else if (strobe_in)
		begin
			// a zero limit behaves as one so the tick never stalls
			if (count + 7'h01 >= limit_in)
			begin
				count <= 7'h00;
				tick_out <= 1'b1;
			end
			else
			begin
				count <= count + 7'h01;
				tick_out <= 1'b0;
			end
		end
		else
			tick_out <= 1'b0;
	end
endmodule

// File: hw/cyclic_task_scheduler.v
// cyclic task scheduler: main, periodic and initialization tasks
`timescale 1ns/100ps
`include "task_sched_regs.vh"

module cyclic_task_scheduler
#(
	parameter CYC_PER_MS = `CYC_PER_MS,
	parameter DW         = 32,
	parameter N_REAL     = `N_REAL_AXES,
	parameter N_VIRT     = `N_VIRT_AXES,
	parameter N_DIN      = `N_DIN,
	parameter N_DOUT     = `N_DOUT,
	parameter N_REMOTE   = `N_REMOTE
)
(
	input  wire                     sys_clk_in,
	input  wire                     rst_in,
	input  wire [2:0]               main_period_ms_in,
	input  wire [6:0]               per_period_ms_in,
	input  wire                     run_req_in,
	input  wire                     phase_done_in,
	input  wire                     per_done_in,
	input  wire                     main_cmd_req_in,
	input  wire                     per_cmd_req_in,
	input  wire [DW-1:0]            result_in,
	input  wire                     result_wr_in,
	input  wire [DW-1:0]            per_result_in,
	input  wire                     per_result_wr_in,
	input  wire [DW-1:0]            slave_in_data_in,
	input  wire [N_DIN-1:0]         din_in,
	input  wire [N_DOUT-1:0]        dout_in,
	input  wire [N_REAL+N_VIRT-1:0] axis_req_in,
	input  wire [N_REMOTE-1:0]      remote_req_in,
	output reg                      run_out,
	output reg  [2:0]               phase_out,
	output reg                      phase_start_out,
	output reg                      per_start_out,
	output reg                      per_run_out,
	output reg                      main_cmd_grant_out,
	output reg                      per_cmd_grant_out,
	output reg                      fb_update_out,
	output reg  [DW-1:0]            slave_out_data_out,
	output reg  [DW-1:0]            slave_in_hold_out,
	output reg  [DW-1:0]            per_apply_out,
	output reg                      per_apply_valid_out,
	output reg  [N_DIN-1:0]         din_out,
	output reg  [N_DOUT-1:0]        dout_out,
	output reg  [N_REAL+N_VIRT-1:0] axis_en_out,
	output reg  [N_REMOTE-1:0]      remote_en_out,
	output reg                      err_out,
	output reg  [15:0]              err_code_out,
	output reg                      cfg_err_out
);
	localparam S_IDLE      = 4'h0;
	localparam S_REFRESH   = 4'h1;
	localparam S_PROG      = 4'h2;
	localparam S_MOTION    = 4'h3;
	localparam S_NET       = 4'h4;
	localparam S_SLACK     = 4'h5;
	localparam S_INIT_REF  = 4'h6;
	localparam S_INIT_PROG = 4'h7;
	localparam S_INIT_WAIT = 4'h8;

	reg  [3:0]        state;
	reg  [2:0]        main_ms;
	reg  [6:0]        per_ms;
	reg               run_req_q;
	reg               start_pend;
	reg               per_pending;
	reg  [DW-1:0]     result_hold;
	reg  [N_DOUT-1:0] dout_hold;
	reg  [DW-1:0]     per_hold;
	reg               per_hold_valid;
	reg  [N_DIN-1:0]  din_meta;
	reg  [N_DIN-1:0]  din_sync;
	wire              ms_tick;
	wire              main_tick;
	wire              per_tick;
	wire              main_ok;
	wire              per_ok;
	wire [6:0]        ratio;
	wire              done_ok;
	wire              slack;

	function main_valid;
		input [2:0] m;
		begin
			main_valid = (m == `MAIN_MS_1) || (m == `MAIN_MS_2) ||
				(m == `MAIN_MS_4);
		end
	endfunction

	function [1:0] main_shift;
		input [2:0] m;
		begin
			case (m)
				`MAIN_MS_2: main_shift = 2'h1;
				`MAIN_MS_4: main_shift = 2'h2;
				default:    main_shift = 2'h0;
			endcase
		end
	endfunction

	function per_valid;
		input [6:0] p;
		input [2:0] m;
		begin
			per_valid = (p >= `PER_MS_MIN) && (p <= `PER_MS_MAX) &&
				((p & ({4'h0, m} - 7'h01)) == 7'h00);
		end
	endfunction

	assign main_ok = main_valid(main_period_ms_in);
	assign per_ok  = per_valid(per_period_ms_in, main_period_ms_in);
	assign ratio   = per_ms >> main_shift(main_ms);
	assign done_ok = phase_done_in && !phase_start_out;
	// the slack window opens only once the main task has finished
	assign slack   = (state == S_SLACK);

	ms_tick_gen #(.DIV(CYC_PER_MS)) u_ms
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.tick_out   (ms_tick)
	);

	// main period ticks come from the free millisecond timer
	period_counter u_main_cnt
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.restart_in (1'b0),
		.strobe_in  (ms_tick),
		.limit_in   ({4'h0, main_ms}),
		.tick_out   (main_tick)
	);

	// periodic ticks count main ticks so they stay aligned to them
	period_counter u_per_cnt
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.restart_in (!run_out),
		.strobe_in  (main_tick),
		.limit_in   (ratio),
		.tick_out   (per_tick)
	);

	// din pins come from outside; two flops before any use
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			din_meta <= {N_DIN{1'b0}};
			din_sync <= {N_DIN{1'b0}};
		end
		else
		begin
			din_meta <= din_in;
			din_sync <= din_meta;
		end
	end

	// task sequencer, mode and error reporting
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state <= S_IDLE;
			run_out <= 1'b0;
			phase_out <= `PH_NONE;
			phase_start_out <= 1'b0;
			run_req_q <= 1'b0;
			start_pend <= 1'b0;
			main_ms <= `MAIN_MS_1;
			per_ms <= `PER_MS_MIN;
			err_out <= 1'b0;
			err_code_out <= `ERR_NONE;
			cfg_err_out <= 1'b0;
		end
		else
		begin
			phase_start_out <= 1'b0;
			err_out <= 1'b0;
			run_req_q <= run_req_in;
			cfg_err_out <= !main_ok || !per_ok;
			if (run_req_in && !run_req_q && !run_out)
			begin
				if (!main_ok)
				begin
					err_out <= 1'b1;
					err_code_out <= `ERR_MAIN_PERIOD;
				end
				else if (!per_ok)
				begin
					err_out <= 1'b1;
					err_code_out <= `ERR_PER_MULT;
				end
				else
					start_pend <= 1'b1;
			end
			if (per_tick && per_pending)
			begin
				// mode is left alone on a periodic overrun
				err_out <= 1'b1;
				err_code_out <= `ERR_PER_OVR;
			end
			if (main_tick)
			begin
				// parameters follow the inputs only while stopped
				if (!run_out && main_ok && per_ok)
				begin
					main_ms <= main_period_ms_in;
					per_ms <= per_period_ms_in;
				end
				phase_out <= `PH_REFRESH;
				phase_start_out <= 1'b1;
				if (state == S_IDLE || state == S_SLACK ||
					state == S_INIT_WAIT)
				begin
					if (start_pend && run_req_in && !run_out)
					begin
						run_out <= 1'b1;
						start_pend <= 1'b0;
						state <= S_INIT_REF;
					end
					else
						state <= S_REFRESH;
				end
				else
				begin
					err_out <= 1'b1;
					run_out <= 1'b0;
					state <= S_REFRESH;
					if (state == S_INIT_REF || state == S_INIT_PROG)
						err_code_out <= `ERR_INIT_OVR;
					else
						err_code_out <= `ERR_MAIN_OVR;
				end
			end
			else if (done_ok)
			begin
				case (state)
					S_REFRESH:
					begin
						// while stopped only the network exchange follows
						phase_start_out <= 1'b1;
						if (run_out)
						begin
							state <= S_PROG;
							phase_out <= `PH_MAIN_PROG;
						end
						else
						begin
							state <= S_NET;
							phase_out <= `PH_NET;
						end
					end
					S_PROG:
					begin
						state <= S_MOTION;
						phase_out <= `PH_MOTION;
						phase_start_out <= 1'b1;
					end
					S_MOTION:
					begin
						state <= S_NET;
						phase_out <= `PH_NET;
						phase_start_out <= 1'b1;
					end
					S_NET:
					begin
						state <= S_SLACK;
						phase_out <= `PH_NONE;
					end
					S_INIT_REF:
					begin
						state <= S_INIT_PROG;
						phase_out <= `PH_INIT_PROG;
						phase_start_out <= 1'b1;
					end
					S_INIT_PROG:
					begin
						state <= S_INIT_WAIT;
						phase_out <= `PH_NONE;
					end
					default:
					begin
						state <= state;
					end
				endcase
			end
			if (!run_req_in)
			begin
				run_out <= 1'b0;
				start_pend <= 1'b0;
			end
		end
	end

	// periodic task bookkeeping
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			per_pending <= 1'b0;
			per_start_out <= 1'b0;
			per_run_out <= 1'b0;
		end
		else
		begin
			per_start_out <= per_tick && run_out;
			if (!run_out)
				per_pending <= 1'b0;
			else if (per_tick)
				per_pending <= 1'b1;
			else if (per_done_in)
				per_pending <= 1'b0;
			// a run may pause here and resume in a later slack window
			per_run_out <= run_out && per_pending && slack &&
				!main_tick && !(per_done_in && !per_tick);
		end
	end

	// motion command arbitration
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			main_cmd_grant_out <= 1'b0;
			per_cmd_grant_out <= 1'b0;
		end
		else
		begin
			main_cmd_grant_out <= main_cmd_req_in;
			per_cmd_grant_out <= per_cmd_req_in && !main_cmd_req_in;
		end
	end

	// data holding: main results wait for the next refresh, periodic results for the end of the next main program phase
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			result_hold <= {DW{1'b0}};
			dout_hold <= {N_DOUT{1'b0}};
			per_hold <= {DW{1'b0}};
			per_hold_valid <= 1'b0;
			slave_out_data_out <= {DW{1'b0}};
			slave_in_hold_out <= {DW{1'b0}};
			per_apply_out <= {DW{1'b0}};
			per_apply_valid_out <= 1'b0;
			din_out <= {N_DIN{1'b0}};
			dout_out <= {N_DOUT{1'b0}};
			fb_update_out <= 1'b0;
			axis_en_out <= {(N_REAL+N_VIRT){1'b0}};
			remote_en_out <= {N_REMOTE{1'b0}};
		end
		else
		begin
			per_apply_valid_out <= 1'b0;
			if (result_wr_in)
			begin
				result_hold <= result_in;
				dout_hold <= dout_in;
			end
			if (main_tick)
			begin
				// stopped outputs go off at the refresh
				slave_out_data_out <= run_out ? result_hold : {DW{1'b0}};
				dout_out <= run_out ? dout_hold : {N_DOUT{1'b0}};
				slave_in_hold_out <= slave_in_data_in;
				din_out <= din_sync;
				axis_en_out <= run_out ? axis_req_in :
					{(N_REAL+N_VIRT){1'b0}};
				remote_en_out <= run_out ? remote_req_in :
					{N_REMOTE{1'b0}};
			end
			// a new periodic result in the take cycle is kept
			if (per_result_wr_in)
			begin
				per_hold <= per_result_in;
				per_hold_valid <= 1'b1;
			end
			else if (done_ok && state == S_PROG && run_out)
				per_hold_valid <= 1'b0;
			if (done_ok && state == S_PROG && run_out && per_hold_valid)
			begin
				per_apply_out <= per_hold;
				per_apply_valid_out <= 1'b1;
			end
			fb_update_out <= run_out && state != S_INIT_REF &&
				state != S_INIT_PROG;
		end
	end
endmodule

// File: dv/sched_checker_assertions.sv
// concurrent checks on the cyclic task scheduler ports
`timescale 1ns/100ps
module sched_checker
(
	input wire        sys_clk_in,
	input wire        rst_in,
	input wire        run_req_in,
	input wire        phase_done_in,
	input wire        main_cmd_req_in,
	input wire        run_out,
	input wire [2:0]  phase_out,
	input wire        phase_start_out,
	input wire        per_run_out,
	input wire        main_cmd_grant_out,
	input wire        per_cmd_grant_out,
	input wire        fb_update_out,
	input wire        err_out,
	input wire [15:0] err_code_out,
	input wire        cfg_err_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_refresh;
		phase_start_out && phase_out == 3'h1;
	endsequence
	sequence s_init;
		phase_start_out && phase_out == 3'h5;
	endsequence
	property p_init_entry;
		$rose(run_out) |-> s_refresh ##[1:40] s_init;
	endproperty
	a_init_entry: assert property (p_init_entry)
		else $error("init task not entered after refresh");
	property p_start_pulse;
		phase_start_out |=> !phase_start_out;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("phase start longer than one cycle");
	property p_run_order;
		phase_out == 3'h2 && phase_done_in && !phase_start_out && run_out
			&& run_req_in |=> phase_out == 3'h3 && phase_start_out;
	endproperty
	a_run_order: assert property (p_run_order)
		else $error("motion phase does not follow program phase");
	property p_tick_refresh;
		$past(phase_out) == 3'h0 && phase_start_out |-> s_refresh;
	endproperty
	a_tick_refresh: assert property (p_tick_refresh)
		else $error("period does not open with refresh");
	property p_main_ovr;
		err_out && err_code_out == 16'h0061 |-> !run_out;
	endproperty
	a_main_ovr: assert property (p_main_ovr)
		else $error("main overrun left the block running");
	property p_per_ovr;
		err_out && err_code_out == 16'h0062 |-> run_out == $past(run_out);
	endproperty
	a_per_ovr: assert property (p_per_ovr)
		else $error("periodic overrun changed the mode");
	property p_init_ovr;
		err_out && err_code_out == 16'h0063 |-> !run_out;
	endproperty
	a_init_ovr: assert property (p_init_ovr)
		else $error("init overrun left the block running");
	property p_cfg_err;
		err_out && err_code_out == 16'h0051 |-> !run_out && cfg_err_out;
	endproperty
	a_cfg_err: assert property (p_cfg_err)
		else $error("main period error without bad config");
	property p_fb_init;
		phase_out == 3'h5 |-> !fb_update_out;
	endproperty
	a_fb_init: assert property (p_fb_init)
		else $error("block outputs updating during init");
	property p_arb;
		main_cmd_req_in |=> main_cmd_grant_out && !per_cmd_grant_out;
	endproperty
	a_arb: assert property (p_arb)
		else $error("main command not granted first");
	property p_slack;
		phase_start_out |-> !per_run_out;
	endproperty
	a_slack: assert property (p_slack)
		else $error("periodic window open in a main phase");
endmodule

bind cyclic_task_scheduler sched_checker i_chk
(
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_req_in(run_req_in),
	.phase_done_in(phase_done_in), .main_cmd_req_in(main_cmd_req_in),
	.run_out(run_out), .phase_out(phase_out),
	.phase_start_out(phase_start_out), .per_run_out(per_run_out),
	.main_cmd_grant_out(main_cmd_grant_out),
	.per_cmd_grant_out(per_cmd_grant_out), .fb_update_out(fb_update_out),
	.err_out(err_out), .err_code_out(err_code_out),
	.cfg_err_out(cfg_err_out)
);

// File: dv/task_executor_model.sv
// behavioural executor of the phases the scheduler starts
`timescale 1ns/100ps
module task_executor_model
#(
	parameter LAT = 2
)
(
	input  wire       sys_clk_in,
	input  wire       rst_in,
	input  wire [2:0] phase_in,
	input  wire       phase_start_in,
	input  wire       per_start_in,
	input  wire       stall_in,
	input  wire       per_hold_in,
	output reg        phase_done_out,
	output reg        per_done_out
);
	integer cnt;
	integer pcnt;
	reg     stall_q;
	reg     hold_q;
	// sampled on the rising edge, clear of the bench's falling-edge drive
	always @(posedge sys_clk_in)
	begin
		stall_q <= stall_in;
		hold_q <= per_hold_in;
	end
	// falling edge so the scheduler samples a settled pulse
	always @(negedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt = 0;
			pcnt = 0;
			phase_done_out <= 1'b0;
			per_done_out <= 1'b0;
		end
		else
		begin
			phase_done_out <= 1'b0;
			per_done_out <= 1'b0;
			if (cnt > 0 && !stall_q)
			begin
				cnt = cnt - 1;
				phase_done_out <= (cnt == 0);
			end
			if (phase_start_in && phase_in != 3'h0)
				cnt = LAT;
			if (pcnt > 0 && !hold_q)
			begin
				pcnt = pcnt - 1;
				per_done_out <= (pcnt == 0);
			end
			if (per_start_in)
				pcnt = 3;
		end
	end
endmodule

// File: dv/testbench.sv
// self-checking bench of the cyclic task scheduler
`timescale 1ns/100ps
module testbench;
	reg         clk;
	reg         rst;
	reg  [2:0]  main_ms;
	reg  [6:0]  per_ms;
	reg         run_req;
	reg         main_cmd;
	reg         per_cmd;
	reg  [31:0] result;
	reg         result_wr;
	reg  [31:0] slave_in;
	reg  [7:0]  dout;
	reg         stall;
	reg         per_hold;
	reg  [31:0] per_res;
	reg         per_res_wr;
	reg  [7:0]  din;
	reg  [35:0] axis;
	reg  [3:0]  remote;
	wire        per_run;
	wire [31:0] per_apply;
	wire        per_apply_v;
	wire [7:0]  din_q;
	wire [35:0] axis_en;
	wire [3:0]  remote_en;
	wire        phase_done;
	wire        per_done;
	wire        run;
	wire [2:0]  phase;
	wire        phase_start;
	wire        per_start;
	wire        main_gnt;
	wire        per_gnt;
	wire        fb_update;
	wire [31:0] slave_out;
	wire [31:0] slave_hold;
	wire [7:0]  dout_q;
	wire        err;
	wire [15:0] err_code;
	wire        cfg_err;
	integer     fails;
	integer     n_tests;

	// short millisecond keeps whole periods within a few dozen cycles
	cyclic_task_scheduler #(.CYC_PER_MS(20)) i_dut
	(
		.sys_clk_in(clk), .rst_in(rst), .main_period_ms_in(main_ms),
		.per_period_ms_in(per_ms), .run_req_in(run_req),
		.phase_done_in(phase_done), .per_done_in(per_done),
		.main_cmd_req_in(main_cmd), .per_cmd_req_in(per_cmd),
		.result_in(result), .result_wr_in(result_wr),
		.per_result_in(per_res), .per_result_wr_in(per_res_wr),
		.slave_in_data_in(slave_in), .din_in(din), .dout_in(dout),
		.axis_req_in(axis), .remote_req_in(remote), .run_out(run),
		.phase_out(phase), .phase_start_out(phase_start),
		.per_start_out(per_start), .per_run_out(per_run),
		.main_cmd_grant_out(main_gnt), .per_cmd_grant_out(per_gnt),
		.fb_update_out(fb_update), .slave_out_data_out(slave_out),
		.slave_in_hold_out(slave_hold), .per_apply_out(per_apply),
		.per_apply_valid_out(per_apply_v), .din_out(din_q),
		.dout_out(dout_q), .axis_en_out(axis_en),
		.remote_en_out(remote_en), .err_out(err),
		.err_code_out(err_code), .cfg_err_out(cfg_err)
	);
	task_executor_model i_exec
	(
		.sys_clk_in(clk), .rst_in(rst), .phase_in(phase),
		.phase_start_in(phase_start), .per_start_in(per_start),
		.stall_in(stall), .per_hold_in(per_hold),
		.phase_done_out(phase_done), .per_done_out(per_done)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	function logic hit(input integer w);
		case (w)
			0: hit = run === 1'b1;
			1: hit = err === 1'b1;
			2: hit = per_start === 1'b1;
			9: hit = phase_start === 1'b1;
			default: hit = phase_start === 1'b1 && phase === 3'(w - 10);
		endcase
	endfunction

	// bounded wait; a miss counts as a mismatch
	task wait_on(input integer w, input integer lim);
		integer i;
	begin
		i = 0;
		do
		begin
			@(negedge clk);
			i = i + 1;
		end
		while (!hit(w) && i < lim);
		if (!hit(w))
			check(32'h0, 32'h1);
	end
	endtask

	task summarize;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	task t_cfg;
		integer k;
	begin
		main_ms = 3'h3;
		repeat (25) @(negedge clk);
		check(cfg_err, 1'b1);
		run_req = 1'b1;
		wait_on(1, 40);
		check(err_code, 16'h0051);
		run_req = 1'b0;
		main_ms = 3'h2;
		per_ms = 7'h03;
		@(negedge clk);
		run_req = 1'b1;
		wait_on(1, 40);
		check(err_code, 16'h0052);
		run_req = 1'b0;
		main_ms = 3'h1;
		per_ms = 7'h65;
		repeat (2) @(negedge clk);
		check(cfg_err, 1'b1);
		for (k = 0; k < 3; k = k + 1)
		begin
			main_ms = 3'h1 << k;
			per_ms = 7'h64;
			repeat (2) @(negedge clk);
			check(cfg_err, 1'b0);
		end
		$display("test config done");
	end
	endtask

	task t_run;
		integer k;
	begin
		main_ms = 3'h1;
		per_ms = 7'h02;
		repeat (100) @(negedge clk);
		run_req = 1'b1;
		wait_on(0, 120);
		check(phase, 3'h1);
		wait_on(15, 20);
		check(fb_update, 1'b0);
		wait_on(11, 40);
		for (k = 2; k < 5; k = k + 1)
		begin
			wait_on(9, 10);
			check(phase, k[2:0]);
		end
		wait_on(2, 100);
		check({phase_start, phase}, 4'h1);
		$display("test run entry done");
	end
	endtask

	task t_data;
	begin
		slave_in = 32'h5a5a0001;
		din = 8'ha5;
		axis = 36'h800000001;
		remote = 4'h9;
		wait_on(12, 40);
		check(fb_update, 1'b1);
		result = 32'hc0de0001;
		dout = 8'h3c;
		result_wr = 1'b1;
		@(negedge clk);
		result_wr = 1'b0;
		wait_on(13, 10);
		check(slave_out === 32'hc0de0001, 1'b0);
		check(per_apply_v, 1'b0);
		per_res = 32'h9e1d0001;
		per_res_wr = 1'b1;
		@(negedge clk);
		per_res_wr = 1'b0;
		wait_on(12, 40);
		check(slave_out, 32'hc0de0001);
		check(dout_q, 8'h3c);
		check(slave_hold, 32'h5a5a0001);
		check(din_q, 8'ha5);
		check(axis_en[31:0], 32'h1);
		check({axis_en[35:32], remote_en}, 8'h89);
		wait_on(13, 10);
		check(per_apply_v, 1'b1);
		check(per_apply, 32'h9e1d0001);
		$display("test data done");
	end
	endtask

	task t_arb;
	begin
		main_cmd = 1'b1;
		per_cmd = 1'b1;
		@(negedge clk);
		check({main_gnt, per_gnt}, 2'h2);
		main_cmd = 1'b0;
		@(negedge clk);
		check(per_gnt, 1'b1);
		per_cmd = 1'b0;
		$display("test arbitration done");
	end
	endtask

	task t_ovr(input integer ph, input logic [15:0] code, input logic mode);
	begin
		if (ph == 5)
			run_req = 1'b1;
		if (ph == 0)
			per_hold = 1'b1;
		else
			wait_on(10 + ph, 60);
		stall = (ph != 0);
		wait_on(1, 200);
		check(err_code, code);
		check(run, mode);
		if (ph == 0)
		begin
			wait_on(14, 30);
			check(per_run, 1'b0);
			repeat (4) @(negedge clk);
			check(per_run, 1'b1);
		end
		stall = 1'b0;
		per_hold = 1'b0;
		if (ph != 0)
			run_req = 1'b0;
		@(negedge clk);
		$display("test overrun done");
	end
	endtask

	initial
	begin
		rst = 1'b1;
		main_ms = 3'h1;
		per_ms = 7'h04;
		run_req = 1'b0;
		main_cmd = 1'b0;
		per_cmd = 1'b0;
		result = 32'h0;
		result_wr = 1'b0;
		slave_in = 32'h0;
		dout = 8'h00;
		stall = 1'b0;
		per_hold = 1'b0;
		per_res = 32'h0;
		per_res_wr = 1'b0;
		din = 8'h00;
		axis = 36'h0;
		remote = 4'h0;
		fails = 0;
		n_tests = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		check({run, phase, err_code}, 20'h0);
		t_cfg;
		t_run;
		t_data;
		t_arb;
		t_ovr(0, 16'h0062, 1'b1);
		t_ovr(2, 16'h0061, 1'b0);
		t_ovr(5, 16'h0063, 1'b0);
		summarize;
	end

	initial
	begin
		#100000;
		fails = fails + 1;
		summarize;
	end
endmodule
